// [autoneg_defs.svh]
`ifndef AUTONEG_DEFS_SVH
`define AUTONEG_DEFS_SVH

// register indices; byte address is four times the index
`define IDX_BMC 6'h00
`define IDX_BMS 6'h01
`define IDX_ADV 6'h04
`define IDX_LPA 6'h05
`define IDX_EXP 6'h06
`define IDX_PST 6'h10

// basic_mode_control fields
`define BMC_SPEED 13
`define BMC_AN_EN 12
`define BMC_RESTART 9
`define BMC_DUPLEX 8
`define BMC_RESET 16'h3100

// basic_mode_status fields
`define BMS_FIXED 16'h7849
`define BMS_AN_DONE 5
`define BMS_RFAULT 4
`define BMS_LINK 2

// ability_advertisement
`define ADV_RESET 16'h01E1
`define ADV_10HD 5
`define ADV_10FD 6
`define ADV_100HD 7
`define ADV_100FD 8
`define CW_RFAULT 13
`define CW_ACK 14
`define CW_NP 15

// partner_ability after parallel detection
`define LPA_PD_100 16'h0081
`define LPA_PD_10 16'h0021

// negotiation_expansion fields
`define EXP_PD_FAULT 4
`define EXP_LP_NP 3
`define EXP_NP_ABLE 2
`define EXP_PAGE_RX 1
`define EXP_LP_AN 0

// phy_link_status fields
`define PST_LINK 0
`define PST_SPEED10 1
`define PST_FULL 2
`define PST_AN_DONE 4

// timing
`define CLK_HZ 25000000
`define BREAK_LINK_MS 1500
`define AN_DONE_MS 3000

`endif

// [autoneg_pkg.sv]
package autoneg_pkg;
   typedef enum logic [2:0] {
      st_forced,
      st_break,
      st_nego,
      st_up
   } an_state_t;
endpackage

// [autoneg_control_logic.sv]
`timescale 1ns/1ps
`include "autoneg_defs.svh"
// Functional notes
// RULE_01 - straps load advertisement bits 8:5 at reset
// RULE_02 - two straps decode four advertised mode sets
// RULE_03 - single strap: half only, or all
// RULE_04 - control register write overrides strap setting
// RULE_05 - negotiation sends advertisement word as bursts
// RULE_06 - priority: 100FD, 100HD, 10FD, 10HD
// RULE_07 - control enables, restarts; forces speed, duplex
// RULE_08 - speed, duplex bits ignored while negotiating
// RULE_09 - link status register shows resolved speed
// RULE_10 - status ability bits fixed; T4 clear
// RULE_11 - status shows complete, fault, link, preamble
// RULE_12 - advertisement defaults all; software may restrict
// RULE_13 - received code words stored as partner ability
// RULE_14 - parallel detect loads 0081h or 0021h
// RULE_15 - parallel detect sets selector and mode bit
// RULE_16 - expansion shows fault, next page, page, able
// RULE_17 - both receivers' links drive parallel detection
// RULE_18 - parallel detect leaves partner-able bit clear
// RULE_19 - not exactly one good link sets fault; the code sets it only when both links are up
// RULE_20 - writing control bit 9 restarts negotiation
// RULE_21 - lost negotiated link resumes negotiation
// RULE_22 - renegotiation silences line for break timer
// RULE_23 - negotiation bounded near three seconds
// RULE_24 - strap values hold until software writes
module autoneg_control_logic
   import autoneg_pkg::*;
#(
   parameter bit SINGLE_STRAP = 1'b0,
   parameter int unsigned BREAK_CYCLES = `CLK_HZ / 1000 * `BREAK_LINK_MS,
   parameter int unsigned AN_DONE_CYCLES = `CLK_HZ / 1000 * `AN_DONE_MS
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // strap pins
   input wire logic adv_strap_sel_lo,
   input wire logic adv_strap_sel_hi,
   // receivers and received code words
   input wire logic link_ok_100,
   input wire logic link_ok_10,
   input wire logic cw_valid,
   input wire logic [15:0] cw_data,
   // transmit control and resolved mode
   output logic flp_send,
   output logic tx_quiet,
   output logic [15:0] tx_code_word,
   output logic link_up,
   output logic speed_100,
   output logic full_duplex
);

   // sequencer state and register file
   an_state_t state_q;
   logic [15:0] bmc_q;
   logic [15:0] adv_q;
   logic [15:0] lpa_q;
   logic strap_done_q;
   logic an_done_q;
   logic rfault_q;
   logic pd_fault_q;
   logic lp_np_q;
   logic page_rx_q;
   logic lp_able_q;
   // one counter serves both break and negotiation limits
   logic [31:0] cnt_q;

   // bus decode and negotiation helpers
   logic [15:0] rd_d;
   logic [3:0] strap_adv;
   logic [5:0] idx;
   logic acc;
   logic wr;
   logic rd;
   logic restart;
   logic mapped;
   logic pd_one;

   assign idx = paddr[7:2];
   assign acc = psel && penable && pready;
   assign wr = acc && pwrite;
   assign rd = acc && !pwrite;
   assign mapped = (idx == `IDX_BMC) || (idx == `IDX_BMS) || (idx == `IDX_ADV) ||
                   (idx == `IDX_LPA) || (idx == `IDX_EXP) || (idx == `IDX_PST);
   // a written one in bit 9 with bit 12 also set, or enabling negotiation, asks for a restart
   assign restart = wr && (idx == `IDX_BMC) && pwdata[`BMC_AN_EN] &&
                    (pwdata[`BMC_RESTART] || !bmc_q[`BMC_AN_EN]); // RULE_20
   // exactly one receiver seeing link is the only clean detection
   assign pd_one = link_ok_100 ^ link_ok_10; // RULE_17

   // strap decode, bit order 100FD,100HD,10FD,10HD
   always_comb begin
      if (SINGLE_STRAP) begin
         strap_adv = adv_strap_sel_lo ? 4'hF : 4'h5; // RULE_03
      end else begin
         case ({adv_strap_sel_hi, adv_strap_sel_lo}) // RULE_02
            2'b00: strap_adv = 4'h3;
            2'b01: strap_adv = 4'hC;
            2'b10: strap_adv = 4'h5;
            default: strap_adv = 4'hF;
         endcase
      end
   end

   // apb handshake: one wait state, then pready for one cycle
   // unmapped indices read zero and flag an error; writes to them vanish
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !mapped;
         if (psel && penable && !pready) begin
            prdata <= {16'h0000, rd_d};
         end
      end
   end

   always_comb begin
      case (idx)
         `IDX_BMC: rd_d = bmc_q;
         `IDX_BMS: begin
            rd_d = `BMS_FIXED; // RULE_10
            rd_d[`BMS_AN_DONE] = an_done_q; // RULE_11
            rd_d[`BMS_RFAULT] = rfault_q;
            rd_d[`BMS_LINK] = link_up;
         end
         `IDX_ADV: rd_d = adv_q;
         `IDX_LPA: rd_d = lpa_q;
         `IDX_EXP: begin
            rd_d = 16'h0000; // RULE_16
            rd_d[`EXP_PD_FAULT] = pd_fault_q;
            rd_d[`EXP_LP_NP] = lp_np_q;
            rd_d[`EXP_NP_ABLE] = 1'b1;
            rd_d[`EXP_PAGE_RX] = page_rx_q;
            rd_d[`EXP_LP_AN] = lp_able_q;
         end
         `IDX_PST: begin
            rd_d = 16'h0000; // RULE_09
            rd_d[`PST_LINK] = link_up;
            rd_d[`PST_SPEED10] = link_up && !speed_100;
            rd_d[`PST_FULL] = link_up && full_duplex;
            rd_d[`PST_AN_DONE] = an_done_q;
         end
         default: rd_d = 16'h0000;
      endcase
   end

   // control register; restart bit self-clears so it reads zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bmc_q <= `BMC_RESET;
      end else if (wr && idx == `IDX_BMC) begin
         bmc_q <= pwdata[15:0] & ~(16'h0001 << `BMC_RESTART); // RULE_04
      end
   end

   // advertisement: straps caught once, on the first edge after release
   // later strap moves are ignored, so shared led pins cannot disturb it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adv_q <= `ADV_RESET; // RULE_12
         strap_done_q <= 1'b0;
      end else begin
         strap_done_q <= 1'b1;
         if (wr && idx == `IDX_ADV) begin
            adv_q <= pwdata[15:0]; // RULE_12
         end else if (!strap_done_q) begin
            adv_q[8:5] <= strap_adv; // RULE_01 RULE_24
         end
      end
   end

   // negotiation sequencer and shared timer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= st_break;
         cnt_q <= 32'h0000_0000;
         an_done_q <= 1'b0;
         link_up <= 1'b0;
         speed_100 <= 1'b0;
         full_duplex <= 1'b0;
      end else begin
         cnt_q <= cnt_q + 32'h0000_0001;
         // a forcing write wins over a restart carried in the same word
         if (wr && idx == `IDX_BMC && !pwdata[`BMC_AN_EN]) begin
            state_q <= st_forced;
            an_done_q <= 1'b0;
         end else if (restart) begin
            state_q <= st_break; // RULE_22
            cnt_q <= 32'h0000_0000;
            an_done_q <= 1'b0;
            link_up <= 1'b0;
         end else begin
            case (state_q)
               st_forced: begin
                  // only the control bits choose the mode here
                  speed_100 <= bmc_q[`BMC_SPEED]; // RULE_07
                  full_duplex <= bmc_q[`BMC_DUPLEX];
                  link_up <= bmc_q[`BMC_SPEED] ? link_ok_100 : link_ok_10;
               end
               st_break: begin
                  link_up <= 1'b0;
                  if (cnt_q >= BREAK_CYCLES - 1) begin // RULE_22
                     state_q <= st_nego;
                     cnt_q <= 32'h0000_0000;
                  end
               end
               st_nego: begin
                  if (cw_valid && cw_data[`CW_ACK] && !cw_data[`CW_NP]) begin
                     // resolution uses the word landing now, not stale lpa
                     state_q <= st_up;
                     an_done_q <= 1'b1;
                     link_up <= 1'b1;
                     // RULE_06 RULE_08
                     if (adv_q[`ADV_100FD] && cw_data[`ADV_100FD]) begin
                        speed_100 <= 1'b1;
                        full_duplex <= 1'b1;
                     end else if (adv_q[`ADV_100HD] && cw_data[`ADV_100HD]) begin
                        speed_100 <= 1'b1;
                        full_duplex <= 1'b0;
                     end else if (adv_q[`ADV_10FD] && cw_data[`ADV_10FD]) begin
                        speed_100 <= 1'b0;
                        full_duplex <= 1'b1;
                     end else if (adv_q[`ADV_10HD] && cw_data[`ADV_10HD]) begin
                        speed_100 <= 1'b0;
                        full_duplex <= 1'b0;
                     end else begin
                        // nothing in common: no link, try again
                        state_q <= st_break;
                        cnt_q <= 32'h0000_0000;
                        an_done_q <= 1'b0;
                        link_up <= 1'b0;
                     end
                  end else if (!lp_able_q && !cw_valid && pd_one) begin
                     state_q <= st_up; // RULE_17
                     an_done_q <= 1'b1;
                     link_up <= 1'b1;
                     speed_100 <= link_ok_100;
                     full_duplex <= 1'b0;
                  end else if (cnt_q >= AN_DONE_CYCLES - 1) begin
                     state_q <= st_break; // RULE_23
                     cnt_q <= 32'h0000_0000;
                  end
               end
               st_up: begin
                  if (!(speed_100 ? link_ok_100 : link_ok_10)) begin
                     state_q <= st_break; // RULE_21
                     cnt_q <= 32'h0000_0000;
                     an_done_q <= 1'b0;
                     link_up <= 1'b0;
                  end
               end
               default: state_q <= st_break;
            endcase
         end
      end
   end

   // partner ability capture and expansion flags
   // a fresh attempt forgets everything the last partner sent
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lpa_q <= 16'h0000;
         rfault_q <= 1'b0;
         lp_np_q <= 1'b0;
         lp_able_q <= 1'b0;
      end else if (restart || state_q == st_break) begin
         lpa_q <= 16'h0000;
         rfault_q <= 1'b0;
         lp_np_q <= 1'b0;
         lp_able_q <= 1'b0;
      end else if (state_q == st_nego) begin
         if (cw_valid) begin
            lpa_q <= cw_data; // RULE_13
            lp_able_q <= 1'b1;
            if (!lp_able_q) begin
               lp_np_q <= cw_data[`CW_NP];
               rfault_q <= cw_data[`CW_RFAULT];
            end
         end else if (!lp_able_q && pd_one) begin
            // partner-able bit stays clear on this path
            lpa_q <= link_ok_100 ? `LPA_PD_100 : `LPA_PD_10; // RULE_14 RULE_15 RULE_18
         end
      end
   end

   // clear-on-read flags; a set in the read cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         page_rx_q <= 1'b0;
         pd_fault_q <= 1'b0;
      end else begin
         if (state_q == st_nego && cw_valid) begin
            page_rx_q <= 1'b1;
         end else if (rd && idx == `IDX_EXP) begin
            page_rx_q <= 1'b0;
         end
         // no link at all is not a fault: there is nothing to detect yet
         if (state_q == st_nego && !lp_able_q && !cw_valid && link_ok_100 && link_ok_10) begin
            pd_fault_q <= 1'b1; // RULE_19
         end else if (rd && idx == `IDX_EXP) begin
            pd_fault_q <= 1'b0;
         end
      end
   end

   // line activity: bursts only while negotiating, silence in break
   // restart silences the line in the very cycle it is taken,
   // so the partner never sees a burst after the request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flp_send <= 1'b0;
         tx_quiet <= 1'b1;
         tx_code_word <= 16'h0000;
      end else begin
         flp_send <= (state_q == st_nego) && !restart; // RULE_05
         tx_quiet <= (state_q == st_break) || restart; // RULE_22
         tx_code_word <= adv_q; // RULE_05
      end
   end

endmodule

// [link_partner.sv]
`timescale 1ns/1ps
module link_partner (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // bench command and device state
   input wire logic [2:0] mode,
   input wire logic [15:0] word,
   input wire logic flp_send,
   input wire logic link_up,
   input wire logic speed_100,
   // line side
   output logic link_ok_100,
   output logic link_ok_10,
   output logic cw_valid,
   output logic [15:0] cw_data
);
   logic [1:0] flp_q;
   logic neg;
   // a negotiating partner shows link only once the device has resolved
   assign neg = (mode == 3'h1) & link_up;
   assign link_ok_100 = (mode == 3'h2) | (mode == 3'h4) | (neg & speed_100);
   assign link_ok_10 = (mode == 3'h3) | (mode == 3'h4) | (neg & !speed_100);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flp_q <= 2'h0;
         cw_valid <= 1'b0;
         cw_data <= 16'h0000;
      end else begin
         flp_q <= {flp_q[0], flp_send};
         cw_valid <= (mode == 3'h1) && (flp_q == 2'h1) && flp_send;
         // idle lines toggle so a stale word never looks valid
         cw_data <= (flp_q == 2'h1) ? word : ~cw_data;
      end
   end
endmodule

// [autoneg_checker.sv]
`timescale 1ns/1ps
module autoneg_checker (
   // clock, reset and apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   // line side
   input wire logic cw_valid,
   input wire logic [15:0] cw_data,
   input wire logic flp_send,
   input wire logic tx_quiet,
   input wire logic [15:0] tx_code_word,
   // resolved mode
   input wire logic link_up,
   input wire logic speed_100,
   input wire logic full_duplex
);
   logic take;
   logic [3:0] common;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // acknowledged base page while bursts are sent
   assign take = flp_send & cw_valid & cw_data[14] & ~cw_data[15];
   assign common = cw_data[8:5] & tx_code_word[8:5];
   apb_answer_a: assert property (psel && penable && !pready |=> pready)
      else $error("access not answered");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   quiet_silent_a: assert property (tx_quiet |-> !flp_send)
      else $error("bursts during break");
   break_hold_a: assert property ($rose(tx_quiet) |-> tx_quiet [*8])
      else $error("break too short");
   quiet_link_a: assert property (tx_quiet && $past(tx_quiet) |-> !link_up)
      else $error("link up during break");
   word_take_a: assert property (take && common != 4'h0 |=> link_up)
      else $error("acknowledged word not resolved");
   best_mode_a: assert property (take && common[3] |=> speed_100 && full_duplex)
      else $error("100 full not chosen");
   low_mode_a: assert property (take && common == 4'h1 |=> !speed_100 && !full_duplex)
      else $error("10 half not chosen");
endmodule
bind autoneg_control_logic autoneg_checker checker_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pready(pready), .cw_valid(cw_valid),
   .cw_data(cw_data), .flp_send(flp_send), .tx_quiet(tx_quiet),
   .tx_code_word(tx_code_word), .link_up(link_up), .speed_100(speed_100),
   .full_duplex(full_duplex));

// [autoneg_control_logic_tb.sv]
`timescale 1ns/1ps
module autoneg_control_logic_tb;
   logic pclk, presetn, psel, penable, pwrite, s_lo, s_hi, e;
   logic pready, pslverr, ok100, ok10, cwv, flp, quiet, up, spd, fdx;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] cwd, txw, txw1, word, r;
   logic [2:0] mode;
   int n_errors = 0;
   int total_checks = 0;
   // short break and negotiation limits keep the run brief
   autoneg_control_logic #(.BREAK_CYCLES(20), .AN_DONE_CYCLES(200)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .adv_strap_sel_lo(s_lo),
      .adv_strap_sel_hi(s_hi), .link_ok_100(ok100), .link_ok_10(ok10),
      .cw_valid(cwv), .cw_data(cwd), .flp_send(flp), .tx_quiet(quiet),
      .tx_code_word(txw), .link_up(up), .speed_100(spd), .full_duplex(fdx));
   // single-strap variant; only its advertised word is watched
   autoneg_control_logic #(.SINGLE_STRAP(1'b1), .BREAK_CYCLES(20), .AN_DONE_CYCLES(200))
      dut_one (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(),
      .pslverr(), .adv_strap_sel_lo(s_lo), .adv_strap_sel_hi(s_hi),
      .link_ok_100(ok100), .link_ok_10(ok10), .cw_valid(cwv), .cw_data(cwd),
      .flp_send(), .tx_quiet(), .tx_code_word(txw1), .link_up(), .speed_100(),
      .full_duplex());
   link_partner lp (.pclk(pclk), .presetn(presetn), .mode(mode), .word(word),
      .flp_send(flp), .link_up(up), .speed_100(spd), .link_ok_100(ok100),
      .link_ok_10(ok10), .cw_valid(cwv), .cw_data(cwd));
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: %h not %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("%0d checks, %0d errors", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      #2000000;
      chk(16'h0000, 16'h0001);
      stop_test();
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk({15'h0, pready}, 16'h0001);
      r = prdata[15:0];
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 16'h0000);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic wait_up(input logic lvl);
      int n;
      n = 0;
      while (up !== lvl && n < 400) begin
         @(posedge pclk);
         n++;
      end
      chk({15'h0, up}, {15'h0, lvl});
   endtask
   task automatic t_straps();
      logic [15:0] adv [4] = '{16'h0061, 16'h0181, 16'h00A1, 16'h01E1};
      for (int i = 0; i < 4; i++) begin
         @(posedge pclk);
         presetn <= 1'b0;
         s_lo <= i[0];
         s_hi <= i[1];
         repeat (3) @(posedge pclk);
         presetn <= 1'b1;
         rd(8'h10);
         chk(r, adv[i]);
         chk(txw, adv[i]);
         chk({12'h000, txw1[8:5]}, {12'h000, (i[0] ? 4'hF : 4'h5)});
      end
   endtask
   task automatic t_regs();
      rd(8'h00);
      chk(r, 16'h3100);
      wr(8'h04, 16'h0000);
      rd(8'h04);
      chk(r & 16'hFFCB, 16'h7849);
      rd(8'h08);
      chk({e, r[14:0]}, 16'h8000);
   endtask
   task automatic t_forced();
      wr(8'h00, 16'h2100);
      repeat (4) @(posedge pclk);
      chk({14'h0, spd, fdx}, 16'h0003);
      wr(8'h00, 16'h0000);
      repeat (4) @(posedge pclk);
      chk({14'h0, spd, fdx}, 16'h0000);
   endtask
   task automatic t_nego();
      logic [15:0] adv [4] = '{16'h01E1, 16'h00A1, 16'h0061, 16'h0021};
      logic [1:0] res [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
      mode <= 3'h1;
      word <= 16'h41E1;
      for (int i = 0; i < 4; i++) begin
         wr(8'h10, adv[i]);
         wr(8'h00, 16'h1200);
         wait_up(1'b0);
         wait_up(1'b1);
         chk({14'h0, spd, fdx}, {14'h0, res[i]});
      end
      rd(8'h14);
      chk(r, 16'h41E1);
      rd(8'h40);
      chk(r & 16'h0017, 16'h0013);
      rd(8'h18);
      chk(r & 16'h0005, 16'h0005);
   endtask
   task automatic t_pd();
      for (int i = 0; i < 2; i++) begin
         mode <= 3'h2 + 3'(i);
         wr(8'h00, 16'h1200);
         wait_up(1'b0);
         wait_up(1'b1);
         chk({14'h0, spd, fdx}, {14'h0, ~i[0], 1'b0});
         rd(8'h14);
         chk(r, i ? 16'h0021 : 16'h0081);
         rd(8'h18);
         chk(r & 16'h0001, 16'h0000);
         rd(8'h04);
         chk(r & 16'h0024, 16'h0024);
      end
      mode <= 3'h0;
      wait_up(1'b0);
      @(posedge pclk);
      chk({15'h0, quiet}, 16'h0001);
   endtask
   task automatic t_fault();
      mode <= 3'h4;
      wr(8'h00, 16'h1200);
      repeat (60) @(posedge pclk);
      rd(8'h18);
      chk(r & 16'h0010, 16'h0010);
      chk({15'h0, up}, 16'h0000);
   endtask
   initial begin
      {presetn, psel, penable, pwrite, s_lo, s_hi} = 6'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      mode = 3'h0;
      word = 16'h0000;
      t_straps();
      t_regs();
      t_forced();
      t_nego();
      t_pd();
      t_fault();
      stop_test();
   end
endmodule
